// *** inc/lvi_pkg.sv ***
// Package for the low-voltage interrupt unit: register map, fields, timing
package lvi_pkg;
    // Register byte offsets
    localparam logic [7:0] CTRL_OFFS = 8'h00;
    localparam logic [7:0] STAT_OFFS = 8'h04;
    localparam logic [7:0] MASK_OFFS = 8'h08;
    localparam logic [7:0] IRQS_OFFS = 8'h0C;
    // Control register fields
    localparam int DET_EN_BIT = 0;
    localparam int FALL_IE_BIT = 1;
    localparam int RISE_IE_BIT = 2;
    // Status register fields
    localparam int FALL_FLAG_BIT = 0;
    localparam int RISE_FLAG_BIT = 1;
    localparam int DETECT_BIT = 2;
    localparam int STANDBY_BIT = 3;
    localparam int LVR_BIT = 4;
    // Event status / mask fields
    localparam int EV_FALL_BIT = 0;
    localparam int EV_RISE_BIT = 1;
    localparam int EV_LVR_BIT = 2;
    localparam int EV_SEQERR_BIT = 3;
    localparam int EV_W = 4;
    // Reset values
    localparam logic [2:0] CTRL_RST = 3'h0;
    localparam logic [1:0] FLAG_RST = 2'h0;
    localparam logic [EV_W-1:0] MASK_RST = 4'h0;
    // AXI responses
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
    // Settling time after detector enable
    localparam int SETTLE_NS = 50000;
    localparam int CLK_NS = 40;
    localparam int SETTLE_CYC = (SETTLE_NS + CLK_NS - 1) / CLK_NS;
    localparam int SETTLE_W = 11;

    typedef struct packed {
        logic rise_ie;
        logic fall_ie;
        logic det_en;
    } lvi_ctrl_t;

    typedef struct packed {
        logic below_reset;
        logic below_upper;
        logic below_lower;
    } lvi_cmp_t;
endpackage

// *** verilog/lvi_unit.sv ***
// Low-voltage detect interrupt unit with AXI4-Lite registers
//
// Local design decisions: the AXI4-Lite register port and the placing of the registers.
`timescale 1ns/1ns
//
// Contract
// - Standby after reset until software enables
// - Drop below lower: detect low, fall flag
// - Fall with enable: interrupt same cycle
// - Rise above upper: detect back high
// - Rise with enable: rise flag and interrupt
// - Below reset threshold: hand to reset function
module lvi_unit
    import lvi_pkg::*;
(
    input wire logic sys_clk_i,
    input wire logic reset_i,
    input wire logic clk_en_i,
    input wire lvi_cmp_t cmp_i,
    output logic detect_signal_n_o,
    output logic external_interrupt_0_o,
    output logic low_voltage_reset_o,
    output logic irq_o,
    input wire logic [7:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [7:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready
);

    typedef enum logic [1:0] {
        LVI_STANDBY = 2'b00,
        LVI_SETTLE = 2'b01,
        LVI_ACTIVE = 2'b10
    } lvi_state_t;

    ////////////////////////////////////////////////////////////////////////
    // State
    lvi_ctrl_t detector_control_reg, next_ctrl;
    logic voltage_fall_flag, next_fall_flag;
    logic voltage_rise_flag, next_rise_flag;
    logic detect_n, next_detect_n;
    logic lvr, next_lvr;
    logic external_interrupt_0, next_external_interrupt_0;
    logic [EV_W-1:0] ev_stat, next_ev_stat;
    logic [EV_W-1:0] ev_mask, next_ev_mask;
    lvi_state_t state, next_state;
    logic [SETTLE_W-1:0] settle_cnt, next_settle_cnt;

    logic aw_held, next_aw_held;
    logic w_held, next_w_held;
    logic [7:0] aw_addr, next_aw_addr;
    logic [31:0] w_data, next_w_data;
    logic [3:0] w_strb, next_w_strb;
    logic bvalid, next_bvalid;
    logic [1:0] bresp, next_bresp;
    logic rvalid, next_rvalid;
    logic [1:0] rresp, next_rresp;
    logic [31:0] rdata, next_rdata;

    logic wr_fire, rd_fire, wr_ctrl, wr_stat, rd_irqs;
    logic fall_ev, rise_ev, lvr_ev, seq_err;
    logic [EV_W-1:0] ev_set;
    logic [31:0] stat_word;

    ////////////////////////////////////////////////////////////////////////
    // Bus handshake: address and data accepted in either order
    // Readies drop while frozen so no request is lost; responses
    // still show, so keep clk_en_i high until they are taken
    assign s_axi_awready = clk_en_i && !aw_held && !bvalid;
    assign s_axi_wready = clk_en_i && !w_held && !bvalid;
    assign s_axi_arready = clk_en_i && !rvalid;
    assign s_axi_bvalid = bvalid;
    assign s_axi_bresp = bresp;
    assign s_axi_rvalid = rvalid;
    assign s_axi_rresp = rresp;
    assign s_axi_rdata = rdata;

    always_comb begin
        next_aw_held = aw_held;
        next_w_held = w_held;
        next_aw_addr = aw_addr;
        next_w_data = w_data;
        next_w_strb = w_strb;
        if (s_axi_awvalid && s_axi_awready) begin
            next_aw_held = 1'b1;
            next_aw_addr = s_axi_awaddr;
        end
        if (s_axi_wvalid && s_axi_wready) begin
            next_w_held = 1'b1;
            next_w_data = s_axi_wdata;
            next_w_strb = s_axi_wstrb;
        end
        // Write lands one edge after both halves are held
        wr_fire = aw_held && w_held && !bvalid;
        if (wr_fire) begin
            next_aw_held = 1'b0;
            next_w_held = 1'b0;
        end
        wr_ctrl = wr_fire && aw_addr == CTRL_OFFS && w_strb[0];
        wr_stat = wr_fire && aw_addr == STAT_OFFS && w_strb[0];
        next_bvalid = bvalid;
        next_bresp = bresp;
        if (wr_fire) begin
            next_bvalid = 1'b1;
            next_bresp = (aw_addr == CTRL_OFFS || aw_addr == STAT_OFFS ||
                          aw_addr == MASK_OFFS || aw_addr == IRQS_OFFS)
                         ? RESP_OKAY : RESP_SLVERR;
        end else if (bvalid && s_axi_bready) begin
            next_bvalid = 1'b0;
        end
    end

    always_comb begin
        stat_word = 32'h0000_0000;
        stat_word[FALL_FLAG_BIT] = voltage_fall_flag;
        stat_word[RISE_FLAG_BIT] = voltage_rise_flag;
        stat_word[DETECT_BIT] = !detect_n;
        stat_word[STANDBY_BIT] = state == LVI_STANDBY;
        stat_word[LVR_BIT] = lvr;
    end

    always_comb begin
        rd_fire = s_axi_arvalid && s_axi_arready;
        rd_irqs = rd_fire && s_axi_araddr == IRQS_OFFS;
        next_rvalid = rvalid;
        next_rresp = rresp;
        next_rdata = rdata;
        if (rd_fire) begin
            next_rvalid = 1'b1;
            next_rresp = RESP_OKAY;
            case (s_axi_araddr)
                CTRL_OFFS: next_rdata = {29'h0, detector_control_reg};
                STAT_OFFS: next_rdata = stat_word;
                MASK_OFFS: next_rdata = {28'h0, ev_mask};
                IRQS_OFFS: next_rdata = {28'h0, ev_stat};
                default: begin
                    // Unmapped reads answer zero with an error
                    next_rdata = 32'h0000_0000;
                    next_rresp = RESP_SLVERR;
                end
            endcase
        end else if (rvalid && s_axi_rready) begin
            next_rvalid = 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Detector logic
    always_comb begin
        next_ctrl = detector_control_reg;
        next_ev_mask = ev_mask;
        next_state = state;
        next_settle_cnt = settle_cnt;
        seq_err = 1'b0;
        if (wr_ctrl) begin
            next_ctrl = w_data[2:0];
            // Early enables or one-write shutdown are flagged, not blocked
            seq_err = (w_data[FALL_IE_BIT] || w_data[RISE_IE_BIT]) &&
                      state != LVI_ACTIVE;
            if (!w_data[DET_EN_BIT] && (detector_control_reg.fall_ie ||
                detector_control_reg.rise_ie)) begin
                seq_err = 1'b1;
            end
        end
        if (wr_fire && aw_addr == MASK_OFFS && w_strb[0]) begin
            next_ev_mask = w_data[EV_W-1:0];
        end
        case (state)
            LVI_STANDBY: begin
                if (detector_control_reg.det_en) begin
                    next_state = LVI_SETTLE;
                    // Settle count loads on entry to the wait
                    next_settle_cnt = SETTLE_W'(SETTLE_CYC - 1);
                end
            end
            LVI_SETTLE: begin
                if (!detector_control_reg.det_en) begin
                    next_state = LVI_STANDBY;
                end else if (settle_cnt == '0) begin
                    next_state = LVI_ACTIVE;
                end else begin
                    next_settle_cnt = settle_cnt - 1'b1;
                end
            end
            LVI_ACTIVE: begin
                if (!detector_control_reg.det_en) begin
                    next_state = LVI_STANDBY;
                end
            end
            default: next_state = LVI_STANDBY;
        endcase
    end

    always_comb begin
        fall_ev = 1'b0;
        rise_ev = 1'b0;
        lvr_ev = 1'b0;
        next_detect_n = detect_n;
        next_lvr = lvr;
        if (state != LVI_ACTIVE) begin
            next_detect_n = 1'b1;
            next_lvr = 1'b0;
        end else begin
            next_lvr = cmp_i.below_reset;
            lvr_ev = cmp_i.below_reset && !lvr;
            if (detect_n && cmp_i.below_lower) begin
                next_detect_n = 1'b0;
                fall_ev = 1'b1;
            // A trip below the reset threshold must clear first
            end else if (!detect_n && !cmp_i.below_upper && !lvr &&
                         !cmp_i.below_reset) begin
                next_detect_n = 1'b1;
                rise_ev = 1'b1;
            end
        end
        // Set wins over a software clear
        next_fall_flag = (wr_stat && !w_data[FALL_FLAG_BIT])
                         ? 1'b0 : voltage_fall_flag;
        next_rise_flag = (wr_stat && !w_data[RISE_FLAG_BIT])
                         ? 1'b0 : voltage_rise_flag;
        if (fall_ev) begin
            next_fall_flag = 1'b1;
        end
        if (rise_ev && detector_control_reg.rise_ie) begin
            next_rise_flag = 1'b1;
        end
        next_external_interrupt_0 = (fall_ev && detector_control_reg.fall_ie) ||
                    (rise_ev && detector_control_reg.rise_ie);
        ev_set = '0;
        ev_set[EV_FALL_BIT] = fall_ev;
        ev_set[EV_RISE_BIT] = rise_ev;
        ev_set[EV_LVR_BIT] = lvr_ev;
        ev_set[EV_SEQERR_BIT] = seq_err;
        // Read-to-clear keeps events raised in the same cycle
        next_ev_stat = (rd_irqs ? '0 : ev_stat) | ev_set;
    end

    ////////////////////////////////////////////////////////////////////////
    // Outputs
    assign detect_signal_n_o = detect_n;
    assign external_interrupt_0_o = external_interrupt_0;
    assign low_voltage_reset_o = lvr;
    assign irq_o = |(ev_stat & ev_mask);

    // Enable low holds every register, bus state included
    always_ff @(posedge sys_clk_i) begin
        if (reset_i) begin
            detector_control_reg <= CTRL_RST;
            voltage_fall_flag <= 1'b0;
            voltage_rise_flag <= 1'b0;
            detect_n <= 1'b1;
            lvr <= 1'b0;
            external_interrupt_0 <= 1'b0;
            ev_stat <= '0;
            ev_mask <= MASK_RST;
            state <= LVI_STANDBY;
            settle_cnt <= '0;
            aw_held <= 1'b0;
            w_held <= 1'b0;
            aw_addr <= '0;
            w_data <= '0;
            w_strb <= '0;
            bvalid <= 1'b0;
            bresp <= RESP_OKAY;
            rvalid <= 1'b0;
            rresp <= RESP_OKAY;
            rdata <= '0;
        end else if (clk_en_i) begin
            detector_control_reg <= next_ctrl;
            voltage_fall_flag <= next_fall_flag;
            voltage_rise_flag <= next_rise_flag;
            detect_n <= next_detect_n;
            lvr <= next_lvr;
            external_interrupt_0 <= next_external_interrupt_0;
            ev_stat <= next_ev_stat;
            ev_mask <= next_ev_mask;
            state <= next_state;
            settle_cnt <= next_settle_cnt;
            aw_held <= next_aw_held;
            w_held <= next_w_held;
            aw_addr <= next_aw_addr;
            w_data <= next_w_data;
            w_strb <= next_w_strb;
            bvalid <= next_bvalid;
            bresp <= next_bresp;
            rvalid <= next_rvalid;
            rresp <= next_rresp;
            rdata <= next_rdata;
        end
    end

endmodule

// *** tb/lvi_supply_model.sv ***
// Supply comparator model driven by a coarse supply level
`timescale 1ns/1ns
module lvi_supply_model
    import lvi_pkg::*;
(
    input wire logic [1:0] level_i,
    output lvi_cmp_t cmp_o
);
    // 0 normal, 1 inside hysteresis band, 2 below lower, 3 below reset
    assign cmp_o.below_upper = (level_i != 2'h0);
    assign cmp_o.below_lower = level_i[1];
    assign cmp_o.below_reset = (level_i == 2'h3);
endmodule

// *** tb/lvi_unit_chk.sv ***
// Port checker for the low-voltage interrupt unit
`timescale 1ns/1ns
module lvi_unit_chk
    import lvi_pkg::*;
(
    input wire logic sys_clk_i,
    input wire logic reset_i,
    input wire lvi_cmp_t cmp_i,
    input wire logic detect_signal_n_o,
    input wire logic external_interrupt_0_o,
    input wire logic low_voltage_reset_o,
    input wire logic irq_o,
    input wire logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic [31:0] s_axi_rdata
);
    default clocking cb @(posedge sys_clk_i); endclocking
    default disable iff (reset_i);
    ////////////////////////////////////////////////////////////////////
    sequence s_pulse;
        external_interrupt_0_o ##1 !external_interrupt_0_o;
    endsequence
    property p_pulse;
        external_interrupt_0_o |-> s_pulse;
    endproperty
    a_pulse: assert property (p_pulse)
        else $error("interrupt pulse longer than one cycle");
    property p_on_edge;
        external_interrupt_0_o |-> $changed(detect_signal_n_o);
    endproperty
    a_on_edge: assert property (p_on_edge)
        else $error("interrupt without detect change");
    property p_fall_cause;
        $fell(detect_signal_n_o) |-> $past(cmp_i.below_lower);
    endproperty
    a_fall_cause: assert property (p_fall_cause)
        else $error("detect fell without low supply");
    property p_rise_cause;
        external_interrupt_0_o && detect_signal_n_o
            |-> $past(!cmp_i.below_upper && !cmp_i.below_reset);
    endproperty
    a_rise_cause: assert property (p_rise_cause)
        else $error("rise interrupt without recovered supply");
    property p_lvr;
        low_voltage_reset_o |-> $past(cmp_i.below_reset);
    endproperty
    a_lvr: assert property (p_lvr)
        else $error("reset handoff without reset threshold");
    property p_start;
        $fell(reset_i) |-> detect_signal_n_o && !low_voltage_reset_o
            && !irq_o && !external_interrupt_0_o;
    endproperty
    a_start: assert property (p_start)
        else $error("outputs not idle after reset");
    property p_rhold;
        s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata);
    endproperty
    a_rhold: assert property (p_rhold)
        else $error("read data dropped before taken");
    property p_rnew;
        $rose(s_axi_rvalid) |-> $past(s_axi_arvalid && s_axi_arready);
    endproperty
    a_rnew: assert property (p_rnew)
        else $error("read answer without request");
endmodule

bind lvi_unit lvi_unit_chk u_chk (.*);

// *** tb/tb.sv ***
// Self-checking bench for the low-voltage interrupt unit
`timescale 1ns/1ns
module tb
    import lvi_pkg::*;
;
    logic sys_clk_i = 0, reset_i = 1, clk_en_i = 1;
    logic [1:0] level = 0;
    lvi_cmp_t cmp_i;
    logic detect_signal_n_o, external_interrupt_0_o;
    logic low_voltage_reset_o, irq_o;
    logic [7:0] s_axi_awaddr = 0, s_axi_araddr = 0;
    logic [31:0] s_axi_wdata = 0, s_axi_rdata;
    logic [3:0] s_axi_wstrb = 4'hF;
    logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0;
    logic s_axi_arvalid = 0, s_axi_rready = 0;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
    logic s_axi_rvalid;
    logic [1:0] s_axi_bresp, s_axi_rresp;
    logic [33:0] rq[$];
    logic [1:0] bq[$];
    int miscompares = 0, tests_run = 0, pulses = 0;

    lvi_unit DUT (.*);
    lvi_supply_model u_sup (.level_i(level), .cmp_o(cmp_i));

    initial forever #20 sys_clk_i = ~sys_clk_i;
    ////////////////////////////////////////////////////////////////////
    task automatic chk(input logic [33:0] seen, input logic [33:0] exp);
        tests_run++;
        if (seen !== exp) begin
            miscompares++;
            $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    task automatic final_report;
        if (miscompares == 0 && tests_run > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d,
                      input logic [3:0] s);
        bq.push_back(RESP_OKAY);
        @(posedge sys_clk_i);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_wstrb <= s;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        do begin
            @(posedge sys_clk_i);
            if (s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wready) s_axi_wvalid <= 1'b0;
        end while (s_axi_bvalid !== 1'b1);
        s_axi_bready <= 1'b0;
    endtask

    // Late rready exercises the slave holding its answer
    task automatic rd(input logic [7:0] a, input logic [33:0] e);
        rq.push_back(e);
        @(posedge sys_clk_i);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        do @(posedge sys_clk_i); while (s_axi_arready !== 1'b1);
        s_axi_arvalid <= 1'b0;
        repeat ($urandom_range(2)) @(posedge sys_clk_i);
        s_axi_rready <= 1'b1;
        do @(posedge sys_clk_i); while (s_axi_rvalid !== 1'b1);
        s_axi_rready <= 1'b0;
    endtask

    task automatic go(input logic [1:0] l, input logic v);
        @(posedge sys_clk_i);
        level <= l;
        repeat (4) @(posedge sys_clk_i);
        for (int i = 0; i < 50 && detect_signal_n_o !== v; i++)
            @(posedge sys_clk_i);
        chk(34'(detect_signal_n_o), 34'(v));
    endtask

    always @(posedge sys_clk_i) begin
        if (external_interrupt_0_o === 1'b1) pulses++;
        if (s_axi_rvalid && s_axi_rready)
            chk({s_axi_rresp, s_axi_rdata}, rq.pop_front());
        if (s_axi_bvalid && s_axi_bready)
            chk(34'(s_axi_bresp), 34'(bq.pop_front()));
    end
    ////////////////////////////////////////////////////////////////////
    initial begin
        logic [3:0] m;
        void'($urandom(57509));
        repeat (20) @(posedge sys_clk_i);
        reset_i <= 1'b0;
        rd(STAT_OFFS, 34'h8);
        go(2'h2, 1'b1);
        go(2'h0, 1'b1);
        m = 4'($urandom_range(15));
        wr(MASK_OFFS, {28'($urandom), m}, 4'hF);
        wr(MASK_OFFS, 32'h0, 4'hE);
        rd(MASK_OFFS, 34'(m));
        wr(MASK_OFFS, 32'hF, 4'hF);
        rd(8'h10, {RESP_SLVERR, 32'h0});
        wr(CTRL_OFFS, 32'h1, 4'hF);
        // Settle wait plus margin for the enable write itself
        repeat (SETTLE_CYC + 2) @(posedge sys_clk_i);
        wr(CTRL_OFFS, 32'h7, 4'hF);
        go(2'h2, 1'b0);
        chk(34'(pulses), 34'h1);
        chk(34'(irq_o), 34'h1);
        rd(IRQS_OFFS, 34'h1);
        rd(IRQS_OFFS, 34'h0);
        chk(34'(irq_o), 34'h0);
        go(2'h1, 1'b0);
        go(2'h0, 1'b1);
        chk(34'(pulses), 34'h2);
        go(2'h3, 1'b0);
        chk(34'(low_voltage_reset_o), 34'h1);
        go(2'h0, 1'b1);
        chk(34'(low_voltage_reset_o), 34'h0);
        // Frozen unit ignores the supply until enabled again
        @(posedge sys_clk_i);
        clk_en_i <= 1'b0;
        level <= 2'h2;
        repeat (8) @(posedge sys_clk_i);
        chk(34'(detect_signal_n_o), 34'h1);
        clk_en_i <= 1'b1;
        repeat (4) @(posedge sys_clk_i);
        chk(34'(detect_signal_n_o), 34'h0);
        go(2'h0, 1'b1);
        chk(34'(pulses), 34'h6);
        rd(IRQS_OFFS, 34'h7);
        wr(CTRL_OFFS, 32'h1, 4'hF);
        wr(CTRL_OFFS, 32'h0, 4'hF);
        rd(IRQS_OFFS, 34'h0);
        rd(STAT_OFFS, 34'hB);
        wr(STAT_OFFS, 32'h0, 4'hF);
        rd(STAT_OFFS, 34'h8);
        wr(CTRL_OFFS, 32'h7, 4'hF);
        rd(IRQS_OFFS, 34'h8);
        wr(CTRL_OFFS, 32'h0, 4'hF);
        rd(IRQS_OFFS, 34'h8);
        // Second reset in mid-run must land in standby again
        @(posedge sys_clk_i);
        reset_i <= 1'b1;
        repeat (2) @(posedge sys_clk_i);
        reset_i <= 1'b0;
        rd(STAT_OFFS, 34'h8);
        go(2'h2, 1'b1);
        final_report();
    end

    initial begin
        repeat (5000) @(posedge sys_clk_i);
        miscompares++;
        final_report();
    end
endmodule
